// >>> hw/ramf_filter.sv
/*
  Reading filter top: register port, averaging stack with plain and
  windowed types in moving or repeating mode, feeding the median stage.
  Assumes binary32 conversions, one at a time under conv_ready, and a
  register master that never overlaps read and write strobes.
*/
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "ramf_params.svh"
module ramf_filter #(
  parameter int DEPTH_MAX = 100
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // conversion stream
  input  wire ramf_pkg::ramf_sample_s conv_in,
  output logic                        conv_ready,
  // auxiliary values
  input  wire ramf_pkg::ramf_sample_s aux_in,
  output ramf_pkg::ramf_sample_s      aux_out,
  // filtered reading
  output ramf_pkg::ramf_sample_s      reading_out,
  output logic                        filter_active_indicator
);
  ramf_pkg::ramf_top_s    st_r;
  ramf_pkg::ramf_top_s    st_nxt;
  ramf_pkg::ramf_float_t  stack_mem [DEPTH_MAX];
  ramf_pkg::ramf_float_t  mem_rd;
  ramf_pkg::ramf_float_t  add_a;
  ramf_pkg::ramf_float_t  add_b;
  ramf_pkg::ramf_float_t  add_sum;
  ramf_pkg::ramf_sample_s med_in;
  ramf_pkg::ramf_sample_s med_out;
  logic                   mem_we;
  logic [6:0]             mem_addr;
  ramf_pkg::ramf_float_t  mem_wdata;
  logic                   med_clear;
  logic                   out_of_win;
  logic [8:0]             dv_r;
  logic [6:0]             cnt_inc;
  logic [31:0]            q_new;

  // magnitude times a small integer, truncating
  function automatic ramf_pkg::ramf_float_t mul_int(input ramf_pkg::ramf_float_t f,
                                                    input logic [6:0] k);
    logic [30:0] prod;
    int          p;
    int          e;
    prod = {7'h00, |f[30:23], f[22:0]} * {24'h000000, k};
    p    = -1;
    for (int i = 0; i < 31; i++)
      if (prod[i])
        p = i;
    e = int'(f[30:23]) + p - 23;
    if (p < 0 || f[30:23] == 8'h00)
      return 32'h00000000;
    if (e >= 255)
      return 32'h7F800000;
    return {1'b0, 8'(e), 23'(prod >> (p - 23))};
  endfunction

  // quotient of the stack sum by depth, rebuilt as binary32
  function automatic ramf_pkg::ramf_float_t norm_quo(input ramf_pkg::ramf_float_t s,
                                                     input logic [31:0] q);
    int p;
    int e;
    p = 24;
    for (int i = 24; i < 32; i++)
      if (q[i])
        p = i;
    e = int'(s[30:23]) + p - 31;
    if (s[30:23] == 8'h00 || e <= 0)
      return 32'h00000000;
    return {s[31], 8'(e), 23'(q >> (p - 23))};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // shared adder and median stage
  ramf_fp_add u_add (
    .a   (add_a),
    .b   (add_b),
    .sum (add_sum)
  );

  assign med_in = (st_r.active && st_r.cfg.median_en) ? st_r.avg : '0;

  ramf_median u_med (
    .clock (clock),
    .rstn  (rstn),
    .rank  (st_r.cfg.rank),
    .clear (med_clear),
    .in_s  (med_in),
    .out_s (med_out)
  );

  // stack storage
  assign mem_rd = stack_mem[st_r.idx];

  always_ff @(posedge clock)
  begin
    if (mem_we)
      stack_mem[mem_addr] <= mem_wdata;
  end

  // band test: |x - first| * 100 against range * pct
  assign out_of_win = mul_int(add_sum, `RAMF_PCT_SCALE) >
                      mul_int(st_r.range_v, st_r.cfg.pct);

  // restoring division step and stack counter increment
  assign dv_r    = {st_r.rem, st_r.num[31]};
  assign q_new   = {st_r.quo[30:0], dv_r >= {2'b00, st_r.cfg.depth}};
  assign cnt_inc = (st_r.count == st_r.cfg.depth) ? st_r.count : st_r.count + 7'h01;

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    st_nxt               = st_r;
    st_nxt.avg.valid     = 1'b0;
    st_nxt.reading.valid = 1'b0;
    st_nxt.rdata         = 32'h00000000;
    st_nxt.aux_out       = aux_in;
    mem_we               = 1'b0;
    mem_addr             = st_r.wr_ptr;
    mem_wdata            = st_r.x;
    add_a                = st_r.acc;
    add_b                = mem_rd;
    med_clear            = 1'b0;

    // averaging sequencer
    case (st_r.st)
      ramf_pkg::st_idle:
      begin
        if (conv_in.valid && st_r.conv_ready)
        begin
          st_nxt.x = conv_in.value;
          if (!st_r.active)
            st_nxt.reading = conv_in;
          else if (st_r.cfg.avg_type == ramf_pkg::avg_none)
            st_nxt.avg = conv_in;
          else if (st_r.cfg.avg_type == ramf_pkg::windowed_average_type
                   && st_r.count != 7'h00)
            st_nxt.st = ramf_pkg::st_check;
          else
            st_nxt.st = ramf_pkg::st_store;
        end
      end
      ramf_pkg::st_check:
      begin
        add_a = st_r.x;
        add_b = {~st_r.first[31], st_r.first[30:0]};
        if (out_of_win)
        begin
          st_nxt.avg = '{valid: 1'b1, value: st_r.x};
          st_nxt.idx = 7'h00;
          st_nxt.st  = ramf_pkg::st_fill;
        end
        else
          st_nxt.st = ramf_pkg::st_store;
      end
      ramf_pkg::st_store:
      begin
        mem_we = 1'b1;
        if (st_r.count == 7'h00)
          st_nxt.first = st_r.x;
        st_nxt.wr_ptr = (st_r.wr_ptr + 7'h01 == st_r.cfg.depth) ? 7'h00
                        : st_r.wr_ptr + 7'h01;
        st_nxt.count  = cnt_inc;
        if (cnt_inc == st_r.cfg.depth)
        begin
          st_nxt.acc = 32'h00000000;
          st_nxt.idx = 7'h00;
          st_nxt.st  = ramf_pkg::st_sum;
        end
        else
          st_nxt.st = ramf_pkg::st_idle;
      end
      ramf_pkg::st_fill:
      begin
        mem_we   = 1'b1;
        mem_addr = st_r.idx;
        st_nxt.idx = st_r.idx + 7'h01;
        if (st_r.idx + 7'h01 == st_r.cfg.depth)
        begin
          st_nxt.first = st_r.x;
          st_nxt.st    = ramf_pkg::st_idle;
          if (st_r.cfg.repeat_mode && st_r.cfg.depth != 7'h01)
          begin
            st_nxt.count  = 7'h01;
            st_nxt.wr_ptr = 7'h01;
          end
          else
          begin
            st_nxt.count  = st_r.cfg.repeat_mode ? 7'h00 : st_r.cfg.depth;
            st_nxt.wr_ptr = 7'h00;
          end
        end
      end
      ramf_pkg::st_sum:
      begin
        st_nxt.acc = add_sum;
        st_nxt.idx = st_r.idx + 7'h01;
        if (!st_r.cfg.repeat_mode && st_r.idx == st_r.wr_ptr)
          st_nxt.first = mem_rd;  // oldest entry now heads the stack
        if (st_r.idx + 7'h01 == st_r.cfg.depth)
        begin
          st_nxt.num  = {1'b1, add_sum[22:0], 8'h00};
          st_nxt.quo  = 32'h00000000;
          st_nxt.rem  = 8'h00;
          st_nxt.dcnt = 5'h00;
          st_nxt.st   = ramf_pkg::st_div;
        end
      end
      ramf_pkg::st_div:
      begin
        st_nxt.quo  = q_new;
        st_nxt.rem  = q_new[0] ? 8'(dv_r - {2'b00, st_r.cfg.depth}) : dv_r[7:0];
        st_nxt.num  = {st_r.num[30:0], 1'b0};
        st_nxt.dcnt = st_r.dcnt + 5'h01;
        if (st_r.dcnt == `RAMF_DIV_LAST)
        begin
          st_nxt.avg = '{valid: 1'b1, value: norm_quo(st_r.acc, q_new)};
          st_nxt.st  = ramf_pkg::st_idle;
          if (st_r.cfg.repeat_mode)
          begin
            st_nxt.count  = 7'h00;
            st_nxt.wr_ptr = 7'h00;
          end
        end
      end
      default:
        st_nxt.st = ramf_pkg::st_idle;
    endcase

    // filtered reading: median output or averaged reading, value held between strobes
    if (st_r.active)
    begin
      if (st_r.cfg.median_en && med_out.valid)
        st_nxt.reading = med_out;
      else if (!st_r.cfg.median_en && st_r.avg.valid)
        st_nxt.reading = st_r.avg;
    end

    // register reads
    if (reg_rd)
    begin
      case (reg_addr)
        `RAMF_ADDR_CTRL:    st_nxt.rdata = {31'h00000000, st_r.active};
        `RAMF_ADDR_CFG:     st_nxt.rdata = {9'h000, st_r.cfg.pct, 1'b0, st_r.cfg.depth,
                                            1'b0, st_r.cfg.rank, st_r.cfg.median_en,
                                            st_r.cfg.repeat_mode, st_r.cfg.avg_type};
        `RAMF_ADDR_RANGE:   st_nxt.rdata = st_r.range_v;
        `RAMF_ADDR_STATUS:  st_nxt.rdata = {17'h00000, st_r.count, 6'h00,
                                            st_r.st != ramf_pkg::st_idle, st_r.active};
        `RAMF_ADDR_READING: st_nxt.rdata = st_r.reading.value;
        default:            st_nxt.rdata = 32'h00000000;
      endcase
    end

    // control and configuration writes restart the stack
    if (reg_wr && (reg_addr == `RAMF_ADDR_CTRL || reg_addr == `RAMF_ADDR_CFG))
    begin
      st_nxt.st     = ramf_pkg::st_idle;
      st_nxt.count  = 7'h00;
      st_nxt.wr_ptr = 7'h00;
      st_nxt.avg.valid = 1'b0;
      med_clear     = 1'b1;
      if (reg_addr == `RAMF_ADDR_CTRL && reg_wdata[`RAMF_CTRL_TOGGLE_BIT])
        st_nxt.active = ~st_r.active;
      if (reg_addr == `RAMF_ADDR_CFG)
      begin
        st_nxt.cfg.avg_type    = ramf_pkg::ramf_avg_type_e'(reg_wdata[1:0]);
        if (reg_wdata[1:0] == 2'b11)
          st_nxt.cfg.avg_type  = ramf_pkg::avg_none;
        st_nxt.cfg.repeat_mode = reg_wdata[`RAMF_CFG_MODE_BIT];
        st_nxt.cfg.median_en   = reg_wdata[`RAMF_CFG_MEDEN_BIT];
        st_nxt.cfg.rank  = reg_wdata[`RAMF_CFG_RANK_LSB +: 3];
        if (st_nxt.cfg.rank == 3'h0)
          st_nxt.cfg.rank = `RAMF_RANK_RST;
        else if (st_nxt.cfg.rank > `RAMF_RANK_MAX)
          st_nxt.cfg.rank = `RAMF_RANK_MAX;
        st_nxt.cfg.depth = reg_wdata[`RAMF_CFG_DEPTH_LSB +: 7];
        if (st_nxt.cfg.depth == 7'h00)
          st_nxt.cfg.depth = 7'h01;
        else if (st_nxt.cfg.depth > 7'(DEPTH_MAX))
          st_nxt.cfg.depth = 7'(DEPTH_MAX);
        st_nxt.cfg.pct = reg_wdata[`RAMF_CFG_PCT_LSB +: 7];
        if (st_nxt.cfg.pct > `RAMF_PCT_MAX)
          st_nxt.cfg.pct = `RAMF_PCT_MAX;
      end
    end
    if (reg_wr && reg_addr == `RAMF_ADDR_RANGE)
      st_nxt.range_v = reg_wdata;

    st_nxt.conv_ready = (st_nxt.st == ramf_pkg::st_idle);
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r            <= '0;
      st_r.cfg.depth  <= `RAMF_DEPTH_RST;
      st_r.cfg.rank   <= `RAMF_RANK_RST;
      st_r.conv_ready <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign reg_rdata               = st_r.rdata;
  assign conv_ready              = st_r.conv_ready;
  assign aux_out                 = st_r.aux_out;
  assign reading_out             = st_r.reading;
  assign filter_active_indicator = st_r.active;
endmodule

// >>> shared/ramf_params.svh
/*
  Constants for the reading average and median filter: register offsets,
  field positions, reset values and limits.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef RAMF_PARAMS_SVH
`define RAMF_PARAMS_SVH
// Summary of operation
// - averaging and median stages may both be active; output passes through both
// - each enable request toggles the master filter enable and its active indicator
// - enabled with type none and median off, conversions pass through unchanged
// - only the primary conversion path is filtered; auxiliary values pass untouched
// - both averaging types take a plain mean over a depth of 1 to 100
// - windowed type takes a tolerance of 0 to 100 percent of range
// - a conversion outside the window fills the whole stack with itself
// - inside the window, windowed type averages exactly like the plain type
// - an out-of-window conversion is output alone and averaging restarts from it
// - moving mode: stack is first-in first-out, mean of stack is the reading
// - moving mode: once full, one new reading per further conversion
// - repeating mode: collect depth conversions, output mean, clear, collect anew
// - median rank 1 to 5, window of twice rank plus one, eleven at most
// - median window slides, newest displaces oldest, median recomputed each update
// - median output is the middle value in ascending order
// - all reading arithmetic uses binary32 floating point
// - tolerance band is centred on the first conversion held in the stack
// - type none disables averaging but leaves the median setting as it is
// - moving mode gives no averaged reading until the stack is full
// - plain and windowed types share one depth setting

// register offsets
`define RAMF_ADDR_CTRL        4'h0
`define RAMF_ADDR_CFG         4'h1
`define RAMF_ADDR_RANGE       4'h2
`define RAMF_ADDR_STATUS      4'h3
`define RAMF_ADDR_READING     4'h4
// field positions
`define RAMF_CTRL_TOGGLE_BIT  0
`define RAMF_CFG_TYPE_LSB     0
`define RAMF_CFG_MODE_BIT     2
`define RAMF_CFG_MEDEN_BIT    3
`define RAMF_CFG_RANK_LSB     4
`define RAMF_CFG_DEPTH_LSB    8
`define RAMF_CFG_PCT_LSB      16
`define RAMF_STAT_ACTIVE_BIT  0
`define RAMF_STAT_BUSY_BIT    1
`define RAMF_STAT_COUNT_LSB   8
// limits and reset values
`define RAMF_DEPTH_MAX        7'h64
`define RAMF_DEPTH_RST        7'h0A
`define RAMF_RANK_MAX         3'h5
`define RAMF_RANK_RST         3'h1
`define RAMF_PCT_MAX          7'h64
`define RAMF_PCT_SCALE        7'h64
`define RAMF_MED_MAX          11
`define RAMF_DIV_LAST         5'h1F
`endif

// >>> shared/ramf_pkg.sv
/*
  Types shared by the reading filter modules.
  Assumes ramf_params.svh on the include path.
*/
`include "ramf_params.svh"
package ramf_pkg;
  typedef logic [31:0] ramf_float_t;

  typedef enum logic [1:0] {
    avg_none              = 2'b00,
    avg_plain             = 2'b01,
    windowed_average_type = 2'b10
  } ramf_avg_type_e;

  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_check = 3'b001,
    st_store = 3'b010,
    st_fill  = 3'b011,
    st_sum   = 3'b100,
    st_div   = 3'b101
  } ramf_state_e;

  typedef struct packed {
    logic        valid;
    ramf_float_t value;
  } ramf_sample_s;

  typedef struct packed {
    ramf_avg_type_e avg_type;
    logic           repeat_mode;
    logic           median_en;
    logic [2:0]     rank;
    logic [6:0]     depth;
    logic [6:0]     pct;
  } ramf_cfg_s;

  typedef struct packed {
    ramf_float_t [`RAMF_MED_MAX-1:0] win;
    logic [3:0]                      fill;
    logic                            pending;
    ramf_sample_s                    out;
  } ramf_med_s;

  typedef struct packed {
    ramf_state_e  st;
    ramf_cfg_s    cfg;
    ramf_float_t  range_v;
    logic         active;
    logic [6:0]   count;
    logic [6:0]   wr_ptr;
    logic [6:0]   idx;
    ramf_float_t  first;
    ramf_float_t  x;
    ramf_float_t  acc;
    logic [31:0]  num;
    logic [31:0]  quo;
    logic [7:0]   rem;
    logic [4:0]   dcnt;
    ramf_sample_s avg;
    ramf_sample_s reading;
    ramf_sample_s aux_out;
    logic [31:0]  rdata;
    logic         conv_ready;
  } ramf_top_s;
endpackage

// >>> hw/ramf_fp_add.sv
/*
  Combinational binary32 adder, truncating, no subnormals.
  Assumes finite normal operands; tiny results flush to zero.
*/
`timescale 1ns/100ps
module ramf_fp_add (
  // operands
  input  wire ramf_pkg::ramf_float_t a,
  input  wire ramf_pkg::ramf_float_t b,
  // result
  output ramf_pkg::ramf_float_t      sum
);
  ramf_pkg::ramf_float_t big;
  ramf_pkg::ramf_float_t sml;
  logic [23:0]           mb;
  logic [23:0]           ms;
  logic [7:0]            d;
  logic [24:0]           s;
  logic [24:0]           sh;
  int                    e;
  int                    p;

  // align, add or subtract magnitudes, renormalise
  always_comb
  begin
    big = a;
    sml = b;
    sh  = 25'h0000000;
    p   = -1;
    if (a[30:0] < b[30:0])
    begin
      big = b;
      sml = a;
    end
    mb = {|big[30:23], big[22:0]};
    ms = {|sml[30:23], sml[22:0]};
    d  = big[30:23] - sml[30:23];
    ms = (d > 8'h17) ? 24'h000000 : (ms >> d);
    if (big[31] == sml[31])
      s = {1'b0, mb} + {1'b0, ms};
    else
      s = {1'b0, mb} - {1'b0, ms};
    e = int'(big[30:23]);
    if (s[24])
    begin
      sh = s >> 1;
      e  = e + 1;
    end
    else
    begin
      for (int k = 0; k < 24; k++)
        if (s[k])
          p = k;
      if (p >= 0)
      begin
        sh = 25'(s << (23 - p));
        e  = e - (23 - p);
      end
    end
    if (p < 0 && !s[24])
      sum = 32'h00000000;
    else if (e <= 0)
      sum = 32'h00000000;
    else if (e >= 255)
      sum = {big[31], 8'hFF, 23'h000000};
    else
      sum = {big[31], 8'(e), sh[22:0]};
  end
endmodule

// >>> hw/ramf_median.sv
/*
  Sliding median stage over up to eleven readings.
  Assumes rank already limited to 1..5 by the caller.
*/
`timescale 1ns/100ps
`include "ramf_params.svh"
module ramf_median (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  // settings
  input  wire logic [2:0]            rank,
  input  wire logic                  clear,
  // reading stream
  input  wire ramf_pkg::ramf_sample_s in_s,
  output ramf_pkg::ramf_sample_s      out_s
);
  localparam int WIN = `RAMF_MED_MAX;

  ramf_pkg::ramf_med_s st_r;
  ramf_pkg::ramf_med_s st_nxt;
  logic [31:0]         key   [WIN];
  logic [3:0]          below [WIN];
  logic [3:0]          wsize;

  assign wsize = {rank, 1'b1};  // twice rank plus one
  assign out_s = st_r.out;

  // order position of each entry within the live window
  for (genvar i = 0; i < WIN; i++)
  begin : g_rank
    assign key[i] = st_r.win[i][31] ? ~st_r.win[i] : {1'b1, st_r.win[i][30:0]};
    always_comb
    begin
      below[i] = 4'h0;
      for (int j = 0; j < WIN; j++)
        if (4'(j) < wsize && (key[j] < key[i] || (key[j] == key[i] && j < i)))
          below[i] = below[i] + 4'h1;
    end
  end

  // shift in, then pick the middle entry next cycle
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.out.valid = 1'b0;
    st_nxt.pending   = 1'b0;
    if (st_r.pending && st_r.fill >= wsize)
    begin
      for (int i = 0; i < WIN; i++)
        if (4'(i) < wsize && below[i] == {1'b0, rank})
          st_nxt.out = '{valid: 1'b1, value: st_r.win[i]};
    end
    if (clear)
      st_nxt.fill = 4'h0;
    else if (in_s.valid)
    begin
      st_nxt.win     = {st_r.win[WIN-2:0], in_s.value};
      st_nxt.pending = 1'b1;
      if (st_r.fill < 4'(WIN))
        st_nxt.fill = st_r.fill + 4'h1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// >>> verification/ramf_filter_asserts.sv
/*
  Port checker for the reading filter.
  Assumes binding to every ramf_filter instance.
*/
`timescale 1ns/100ps
module ramf_filter_asserts #(
  parameter int DEPTH_MAX = 100
) (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rstn,
  // register port
  input wire logic [3:0]             reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  // streams
  input wire ramf_pkg::ramf_sample_s conv_in,
  input wire logic                   conv_ready,
  input wire ramf_pkg::ramf_sample_s aux_in,
  input wire ramf_pkg::ramf_sample_s aux_out,
  input wire ramf_pkg::ramf_sample_s reading_out,
  input wire logic                   filter_active_indicator
);
  logic [1:0] ty_r;
  logic       med_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // track averaging type and median enable
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ty_r  <= 2'h0;
      med_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == 4'h1)
    begin
      ty_r  <= reg_wdata[1:0];
      med_r <= reg_wdata[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_toggle_enable: assert property (
    reg_wr && reg_addr == 4'h0 && reg_wdata[0]
    |=> filter_active_indicator != $past(filter_active_indicator))
    else $error("enable did not toggle");
  a_enable_hold: assert property (
    !(reg_wr && reg_addr == 4'h0) |=> $stable(filter_active_indicator))
    else $error("enable changed without request");
  a_status_active: assert property (
    reg_rd && reg_addr == 4'h3 |=> reg_rdata[0] == $past(filter_active_indicator))
    else $error("status active bit wrong");
  a_pass_off: assert property (
    conv_in.valid && conv_ready && !reg_wr && !filter_active_indicator
    |=> reading_out.valid && reading_out.value == $past(conv_in.value))
    else $error("inactive conversion not passed");
  a_pass_on: assert property (
    conv_in.valid && conv_ready && !reg_wr && filter_active_indicator
    && (ty_r == 2'h0 || ty_r == 2'h3) && !med_r
    |-> ##2 reading_out.valid && reading_out.value == $past(conv_in.value, 2))
    else $error("unfiltered conversion not passed");
  a_aux_copy: assert property (
    aux_in.valid |=> aux_out == $past(aux_in))
    else $error("auxiliary value altered");
  a_strobe_single: assert property (
    reading_out.valid && filter_active_indicator |=> !reading_out.valid)
    else $error("reading strobe longer than one cycle");
  a_value_holds: assert property (
    !reading_out.valid |-> $stable(reading_out.value))
    else $error("reading value changed without strobe");
  a_store_busy: assert property (
    conv_in.valid && conv_ready && !reg_wr && filter_active_indicator && ty_r == 2'h1
    |=> !conv_ready)
    else $error("stack store did not drop ready");
endmodule

bind ramf_filter ramf_filter_asserts #(.DEPTH_MAX(DEPTH_MAX)) u_ramf_filter_asserts (
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_in(conv_in),
  .conv_ready(conv_ready), .aux_in(aux_in), .aux_out(aux_out),
  .reading_out(reading_out), .filter_active_indicator(filter_active_indicator)
);

// >>> verification/ramf_front_end.sv
/*
  Front end model offering binary32 conversions one at a time.
  Assumes the filter takes a conversion on an edge with ready high.
*/
`timescale 1ns/100ps
module ramf_front_end (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // conversion stream
  input  wire logic              conv_ready,
  output ramf_pkg::ramf_sample_s conv
);
  // idle line carries no valid
  initial
  begin
    conv = '0;
  end

  // hold the offer until taken, then drop it with a changed value
  task automatic send(input logic [31:0] v, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    conv <= {1'b1, v};
    do
      @(posedge clock);
    while (conv_ready !== 1'b1 || !rstn);
    conv <= {1'b0, ~v};
  endtask
endmodule

// >>> verification/reading_average_median_filter_bench.sv
/*
  Self-checking bench for the reading filter.
  Assumes the front end model and the port checker beside it.
*/
`timescale 1ns/100ps
module reading_average_median_filter_bench;
  localparam logic [31:0] F1 = 32'h3F80_0000;
  localparam logic [31:0] F2 = 32'h4000_0000;
  localparam logic [31:0] F3 = 32'h4040_0000;
  localparam logic [31:0] F4 = 32'h4080_0000;
  localparam logic [31:0] F5 = 32'h40A0_0000;
  localparam logic [31:0] F6 = 32'h40C0_0000;
  localparam logic [31:0] F7 = 32'h40E0_0000;
  localparam logic [31:0] F9 = 32'h4110_0000;
  localparam logic [31:0] FA = 32'h4120_0000;
  localparam logic [31:0] FQ = 32'h4088_0000;
  localparam logic [31:0] FH = 32'h4090_0000;
  logic                   clock;
  logic                   rstn;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [31:0]            reg_rdata;
  ramf_pkg::ramf_sample_s conv_in;
  logic                   conv_ready;
  ramf_pkg::ramf_sample_s aux_in;
  ramf_pkg::ramf_sample_s aux_out;
  ramf_pkg::ramf_sample_s reading_out;
  logic                   filter_active_indicator;
  int                     mismatches;
  int                     n_compared;
  int                     rd_cnt;
  logic [31:0]            rd_val;
  logic [31:0]            got;

  ramf_filter u_ramf_filter (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_in(conv_in),
    .conv_ready(conv_ready), .aux_in(aux_in), .aux_out(aux_out),
    .reading_out(reading_out), .filter_active_indicator(filter_active_indicator)
  );
  ramf_front_end u_ramf_front_end (
    .clock(clock), .rstn(rstn), .conv_ready(conv_ready), .conv(conv_in)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock source
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // count and keep filtered readings
  always @(posedge clock)
  begin
    if (reading_out.valid === 1'b1)
    begin
      rd_cnt <= rd_cnt + 1;
      rd_val <= reading_out.value;
    end
  end

  function automatic logic [31:0] cfg(input logic [1:0] ty, input logic rp,
    input logic md, input logic [2:0] rk, input logic [6:0] dp, input logic [6:0] pc);
    cfg = {9'h000, pc, 1'b0, dp, 1'b0, rk, md, rp, ty};
  endfunction

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] act);
    n_compared++;
    if (act !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // offer one conversion, then look for a reading within a bound
  task automatic conv(input logic [31:0] v, input logic want, input logic [31:0] e);
    int c0;
    int i;
    c0 = rd_cnt;
    u_ramf_front_end.send(v, 1);
    for (i = 0; i < 150 && rd_cnt == c0; i++)
      @(posedge clock);
    check_word("reading seen", {31'h0, want}, {31'h0, rd_cnt != c0});
    if (want)
      check_word("reading", e, rd_val);
  endtask

  task automatic summarize;
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    summarize;
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    aux_in = '0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd(4'h1, got);
    check_word("cfg reset", 32'h0000_0A10, got);
    rd(4'h5, got);
    check_word("unmapped", 32'h0, got);
    conv(F1, 1'b1, F1);
    wr(4'h0, 32'h1);
    check_word("active", 32'h1, {31'h0, filter_active_indicator});
    rd(4'h3, got);
    check_word("status", 32'h1, got & 32'h1);
    conv(F2, 1'b1, F2);
    wr(4'h2, FA);
    wr(4'h1, cfg(2'h1, 1'b0, 1'b0, 3'h1, 7'h02, 7'h00));
    conv(F1, 1'b0, 32'h0);
    conv(F3, 1'b1, F2);
    conv(F5, 1'b1, F4);
    @(posedge clock);
    aux_in <= {1'b1, F7};
    @(posedge clock);
    aux_in <= {1'b0, ~F7};
    #1;
    check_word("aux", F7, aux_out.value);
    wr(4'h1, cfg(2'h1, 1'b1, 1'b0, 3'h1, 7'h02, 7'h00));
    conv(F1, 1'b0, 32'h0);
    rd(4'h3, got);
    check_word("stack count", 32'h0000_0101, got);
    conv(F3, 1'b1, F2);
    conv(F5, 1'b0, 32'h0);
    conv(F7, 1'b1, F6);
    wr(4'h1, cfg(2'h2, 1'b0, 1'b0, 3'h1, 7'h02, 7'h0A));
    conv(F4, 1'b0, 32'h0);
    conv(FH, 1'b1, FQ);
    conv(F9, 1'b1, F9);
    conv(F9, 1'b1, F9);
    wr(4'h1, cfg(2'h1, 1'b0, 1'b1, 3'h1, 7'h01, 7'h00));
    conv(F5, 1'b0, 32'h0);
    conv(F1, 1'b0, 32'h0);
    conv(F3, 1'b1, F3);
    conv(F9, 1'b1, F3);
    conv(F7, 1'b1, F7);
    rd(4'h4, got);
    check_word("reading reg", F7, got);
    wr(4'h1, cfg(2'h3, 1'b0, 1'b1, 3'h7, 7'h7F, 7'h7F));
    rd(4'h1, got);
    check_word("cfg limits", cfg(2'h0, 1'b0, 1'b1, 3'h5, 7'h64, 7'h64), got);
    wr(4'h0, 32'h1);
    check_word("inactive", 32'h0, {31'h0, filter_active_indicator});
    summarize;
  end
endmodule
